// ### logic/sdf_pkg.sv
package sdf_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 20000000; // System clock rate
  localparam int unsigned IDLE_TIME_MS = 1000; // Standstill before idle current
  localparam int unsigned IDLE_CYCLES = CLK_HZ / 1000 * IDLE_TIME_MS;
  // Filter bandwidths in kHz, each filter rejects pulses shorter than half its period
  // A full period hold would halve the top step rate, so half a period is the limit
  localparam int unsigned FILT_LOW_KHZ = 150;
  localparam int unsigned FILT_HIGH_KHZ = 2000;
  localparam int unsigned FILT_LOW_CYCLES = CLK_HZ / (FILT_LOW_KHZ * 2000); // Round down
  localparam int unsigned FILT_HIGH_CYCLES = CLK_HZ / (FILT_HIGH_KHZ * 2000);
  localparam int unsigned MAX_STEP_KHZ = 2000; // Highest legal step rate
  // Self test: two revolutions each way at one revolution per second
  localparam int unsigned TEST_REVS = 2;
  localparam int unsigned TEST_RPS = 1;

  // ==========================================================
  // Current settings in milliamps
  // ==========================================================
  localparam logic [11:0] CUR_MA_0 = 12'h12C; // 0.3 A
  localparam logic [11:0] CUR_MA_1 = 12'h1F4; // 0.5 A
  localparam logic [11:0] CUR_MA_2 = 12'h2BC; // 0.7 A
  localparam logic [11:0] CUR_MA_3 = 12'h3E8; // 1.0 A
  localparam logic [11:0] CUR_MA_4 = 12'h514; // 1.3 A
  localparam logic [11:0] CUR_MA_5 = 12'h640; // 1.6 A
  localparam logic [11:0] CUR_MA_6 = 12'h76C; // 1.9 A
  localparam logic [11:0] CUR_MA_7 = 12'h898; // 2.2 A
  localparam logic [6:0] IDLE_PCT_LOW = 7'h32; // 50 percent
  localparam logic [6:0] IDLE_PCT_HIGH = 7'h5A; // 90 percent
  localparam logic [6:0] RUN_PCT = 7'h64; // 100 percent

  // ==========================================================
  // Microstep resolutions, steps per revolution
  // ==========================================================
  localparam logic [14:0] RES_BASE = 15'h00C8; // 200, doubled by code 0..7
  localparam logic [14:0] RES_8 = 15'h03E8;
  localparam logic [14:0] RES_9 = 15'h07D0;
  localparam logic [14:0] RES_10 = 15'h0FA0;
  localparam logic [14:0] RES_11 = 15'h1388;
  localparam logic [14:0] RES_12 = 15'h1F40;
  localparam logic [14:0] RES_13 = 15'h2710;
  localparam logic [14:0] RES_14 = 15'h4E20;
  localparam logic [14:0] RES_15 = 15'h61A8;

  // Self test states
  typedef enum logic [1:0] {
    SDF_ST_IDLE = 2'b00,
    SDF_ST_CW = 2'b01,
    SDF_ST_CCW = 2'b10,
    SDF_ST_DONE = 2'b11
  } sdf_test_t;

  // Switch value from an ON/OFF contact: OFF reads as 1
  function automatic logic [3:0] sdf_sw_code(input logic [3:0] off_bits);
    return off_bits;
  endfunction : sdf_sw_code

endpackage : sdf_pkg

// ### logic/sdf_filter.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_filter
  import sdf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic raw_in,
  input wire logic low_bw_in,
  output logic clean_out
);

  // ==========================================================
  // Synchroniser
  // ==========================================================
  logic meta_q; // First stage, read only by sync_q
  logic sync_q;
  logic [7:0] cnt_q; // Cycles the new level has held
  logic clean_q;
  logic [7:0] need;

  // Two flops bring the isolated input in
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  // Hold time required depends on bandwidth choice
  assign need = low_bw_in ? 8'(FILT_LOW_CYCLES) : 8'(FILT_HIGH_CYCLES);

  // ==========================================================
  // Glitch filter: level must hold half a period before it passes
  // ==========================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 8'h00;
      clean_q <= 1'b0;
    end else if (sync_q == clean_q) begin
      cnt_q <= 8'h00; // No change pending
    end else if (cnt_q + 8'h01 >= need) begin
      clean_q <= sync_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign clean_out = clean_q;

endmodule : sdf_filter
`default_nettype wire

// ### logic/sdf_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_front_end
  import sdf_pkg::*;
#(
  parameter int unsigned IDLE_CNT = IDLE_CYCLES, // Shorten for simulation
  parameter int unsigned TEST_STEP_DIV = CLK_HZ / 200, // Cycles per step at 200 steps/rev
  parameter int unsigned SMOOTH_DIV = 16 // Smoothing rate divider
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in, // Step pulse, active on falling edge
  input wire logic rotation_sense_in, // High clockwise
  input wire logic amplifier_disable_in, // High means closed
  input wire logic protection_error_in, // Level from protection circuits
  input wire logic current_select_bit0_in, // OFF reads 1
  input wire logic current_select_bit1_in,
  input wire logic current_select_bit2_in,
  input wire logic idle_level_select_in, // ON reads 0
  input wire logic resolution_select_bit0_in,
  input wire logic resolution_select_bit1_in,
  input wire logic resolution_select_bit2_in,
  input wire logic resolution_select_bit3_in,
  input wire logic selftest_switch_in, // ON reads 0
  input wire logic smoothing_switch_in, // ON reads 0
  input wire logic inertia_switch_in, // ON reads 0
  input wire logic input_filter_switch_in, // ON reads 0
  output logic microstep_out, // One-cycle advance pulse
  output logic microstep_cw_out, // Direction of that advance
  output logic amplifier_on_out, // Power switch drive enable
  output logic fault_out, // High means output closed
  output logic [11:0] current_ma_out, // Current target in mA
  output logic [14:0] resolution_out, // Steps per revolution
  output logic high_inertia_out,
  output logic selftest_busy_out
);

  // ==========================================================
  // Input filtering
  // ==========================================================
  logic step_f; // Filtered step
  logic dir_f; // Filtered direction
  logic low_bw; // 150 kHz chosen

  assign low_bw = ~input_filter_switch_in;

  sdf_filter u_step_filt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(step_in),
    .low_bw_in(low_bw),
    .clean_out(step_f)
  );

  sdf_filter u_dir_filt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .raw_in(rotation_sense_in),
    .low_bw_in(low_bw),
    .clean_out(dir_f)
  );

  // ==========================================================
  // Step edge detection and enable sync
  // ==========================================================
  logic step_prev_q;
  logic step_fall; // rate limited by 2 MHz filter period
  logic en_meta_q; // First stage only
  logic en_sync_q;
  logic en_prev_q;
  logic en_fall;

  // Edge history registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_prev_q <= 1'b0;
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_f;
      en_meta_q <= amplifier_disable_in;
      en_sync_q <= en_meta_q;
      en_prev_q <= en_sync_q;
    end
  end

  assign step_fall = step_prev_q & ~step_f;
  assign en_fall = en_prev_q & ~en_sync_q;

  // ==========================================================
  // Error latch
  // ==========================================================
  logic err_q;
  logic prot_q; // Registered protection level

  // Set wins over clear, recovery only once cause gone
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prot_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      prot_q <= protection_error_in;
      if (prot_q) begin
        err_q <= 1'b1;
      end else if (en_fall) begin
        err_q <= 1'b0;
      end
    end
  end

  // Amplifier and fault pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      amplifier_on_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      amplifier_on_out <= ~en_sync_q & ~err_q & ~prot_q;
      fault_out <= err_q | prot_q;
    end
  end

  // ==========================================================
  // Self test sequencer
  // ==========================================================
  sdf_test_t test_q;
  logic [31:0] test_div_q; // Step spacing timer
  logic [31:0] test_left_q; // Steps remaining in this leg
  logic test_pulse; // Step request from the sequencer
  logic st_prev_q; // Last switch sample, ON is 0
  logic [31:0] test_steps;

  // Fixed 200 step/rev pace gives 1 rps only at the 200 step/rev resolution
  assign test_steps = TEST_REVS * 200;
  assign test_pulse = (test_q == SDF_ST_CW || test_q == SDF_ST_CCW) && test_div_q == 32'h0;

  // Switch turned ON after power-up starts one test
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_q <= SDF_ST_IDLE;
      test_div_q <= 32'h0;
      test_left_q <= 32'h0;
      st_prev_q <= 1'b1;
    end else begin
      st_prev_q <= selftest_switch_in;
      case (test_q)
        SDF_ST_IDLE: begin
          if (st_prev_q && !selftest_switch_in && amplifier_on_out) begin
            test_q <= SDF_ST_CW;
            test_left_q <= test_steps;
            test_div_q <= TEST_STEP_DIV / TEST_RPS - 1; // Timer counts through zero
          end
        end
        SDF_ST_CW, SDF_ST_CCW: begin
          if (selftest_switch_in || !amplifier_on_out) begin
            test_q <= SDF_ST_DONE; // Abort
          end else if (test_div_q != 32'h0) begin
            test_div_q <= test_div_q - 32'h1;
          end else begin
            test_div_q <= TEST_STEP_DIV / TEST_RPS - 1;
            if (test_left_q == 32'h1) begin
              test_left_q <= test_steps;
              test_q <= (test_q == SDF_ST_CW) ? SDF_ST_CCW : SDF_ST_DONE;
            end else begin
              test_left_q <= test_left_q - 32'h1;
            end
          end
        end
        SDF_ST_DONE: begin
          if (selftest_switch_in) begin
            test_q <= SDF_ST_IDLE; // Rearm when switched OFF
          end
        end
        default: test_q <= SDF_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Command smoothing
  // ==========================================================
  logic [7:0] pend_q; // Signed backlog of steps
  logic [15:0] sm_div_q;
  logic sm_emit;
  logic cmd_step;
  logic cmd_cw;
  logic test_busy;

  assign test_busy = (test_q == SDF_ST_CW) || (test_q == SDF_ST_CCW);
  assign cmd_step = test_busy ? test_pulse : step_fall;
  assign cmd_cw = test_busy ? (test_q == SDF_ST_CW) : dir_f;
  assign sm_emit = (pend_q != 8'h00) && (sm_div_q == 16'h0);

  // Backlog drains at a bounded rate, trading delay for less jerk
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q <= 8'h00;
      sm_div_q <= 16'h0;
    end else begin
      sm_div_q <= (sm_div_q == 16'h0) ? 16'(SMOOTH_DIV - 1) : sm_div_q - 16'h1;
      if (smoothing_switch_in) begin
        pend_q <= 8'h00; // Unfiltered mode keeps no backlog
      end else begin
        pend_q <= pend_q + (cmd_step ? (cmd_cw ? 8'h01 : 8'hFF) : 8'h00)
                  - (sm_emit ? (pend_q[7] ? 8'hFF : 8'h01) : 8'h00);
      end
    end
  end

  // Step pulse to the current regulator
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      microstep_out <= 1'b0;
      microstep_cw_out <= 1'b1;
    end else if (!amplifier_on_out) begin
      microstep_out <= 1'b0; // No motion while unpowered
    end else if (smoothing_switch_in) begin
      microstep_out <= cmd_step;
      if (cmd_step) begin
        microstep_cw_out <= cmd_cw;
      end
    end else begin
      microstep_out <= sm_emit;
      if (sm_emit) begin
        microstep_cw_out <= ~pend_q[7];
      end
    end
  end

  // ==========================================================
  // Current setting and idle reduction
  // ==========================================================
  logic [31:0] idle_cnt_q;
  logic idle_q;
  logic [11:0] run_ma;
  logic [6:0] pct;
  logic [18:0] scaled;

  // Map three switch bits to peak milliamps
  always_comb begin
    case (sdf_sw_code({1'b0, current_select_bit2_in, current_select_bit1_in,
                       current_select_bit0_in}))
      4'h0: run_ma = CUR_MA_0;
      4'h1: run_ma = CUR_MA_1;
      4'h2: run_ma = CUR_MA_2;
      4'h3: run_ma = CUR_MA_3;
      4'h4: run_ma = CUR_MA_4;
      4'h5: run_ma = CUR_MA_5;
      4'h6: run_ma = CUR_MA_6;
      default: run_ma = CUR_MA_7;
    endcase
  end

  // Standstill timer restarts on every executed step
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt_q <= 32'h0;
      idle_q <= 1'b0;
    end else if (microstep_out) begin
      idle_cnt_q <= 32'h0;
      idle_q <= 1'b0;
    end else if (idle_cnt_q >= IDLE_CNT - 1) begin
      idle_q <= 1'b1;
    end else begin
      idle_cnt_q <= idle_cnt_q + 32'h1;
    end
  end

  assign pct = !idle_q ? RUN_PCT : (idle_level_select_in ? IDLE_PCT_HIGH : IDLE_PCT_LOW);
  // Product needs 19 bits before the divide
  assign scaled = (19'(run_ma) * 19'(pct)) / 19'(RUN_PCT);

  // ==========================================================
  // Resolution and inertia configuration
  // ==========================================================
  logic [3:0] res_code;
  logic [14:0] res_val;

  assign res_code = sdf_sw_code({resolution_select_bit3_in, resolution_select_bit2_in,
                                 resolution_select_bit1_in, resolution_select_bit0_in});

  // Doubling series below 8, table above
  always_comb begin
    case (res_code)
      4'h8: res_val = RES_8;
      4'h9: res_val = RES_9;
      4'hA: res_val = RES_10;
      4'hB: res_val = RES_11;
      4'hC: res_val = RES_12;
      4'hD: res_val = RES_13;
      4'hE: res_val = RES_14;
      4'hF: res_val = RES_15;
      default: res_val = RES_BASE << res_code[2:0];
    endcase
  end

  // Registered configuration outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      current_ma_out <= 12'h000;
      resolution_out <= RES_BASE;
      high_inertia_out <= 1'b0;
      selftest_busy_out <= 1'b0;
    end else begin
      current_ma_out <= amplifier_on_out ? scaled[11:0] : 12'h000;
      resolution_out <= res_val;
      high_inertia_out <= ~inertia_switch_in;
      selftest_busy_out <= test_busy;
    end
  end

endmodule : sdf_front_end
`default_nettype wire

// ### tb/sdf_front_end_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_front_end_monitor
  import sdf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic amplifier_disable_in,
  input wire logic protection_error_in,
  input wire logic resolution_select_bit0_in,
  input wire logic resolution_select_bit1_in,
  input wire logic resolution_select_bit2_in,
  input wire logic resolution_select_bit3_in,
  input wire logic inertia_switch_in,
  input wire logic selftest_switch_in,
  input wire logic microstep_out,
  input wire logic amplifier_on_out,
  input wire logic fault_out,
  input wire logic [11:0] current_ma_out,
  input wire logic [14:0] resolution_out,
  input wire logic high_inertia_out,
  input wire logic selftest_busy_out
);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Steps per revolution by switch code, OFF reads 1
  localparam logic [14:0] RES_T [16] = '{15'h00C8, 15'h0190, 15'h0320, 15'h0640, 15'h0C80,
    15'h1900, 15'h3200, 15'h6400, RES_8, RES_9, RES_10, RES_11, RES_12, RES_13, RES_14, RES_15};
  logic [3:0] res_code; // Switch code as one field
  assign res_code = {resolution_select_bit3_in, resolution_select_bit2_in,
    resolution_select_bit1_in, resolution_select_bit0_in};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // Properties
  // ==========================================================
  property p_step_pulse; microstep_out |=> !microstep_out; endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("microstep wider than one cycle");
  property p_step_amp; microstep_out |-> amplifier_on_out; endproperty
  a_step_amp: assert property (p_step_amp) else $error("microstep while amplifier off");
  property p_dis_off; amplifier_disable_in [*4] |-> !amplifier_on_out; endproperty
  a_dis_off: assert property (p_dis_off) else $error("amplifier on while disabled");
  property p_no_cur; !amplifier_on_out [*2] |-> current_ma_out == 12'h000; endproperty
  a_no_cur: assert property (p_no_cur) else $error("current while amplifier off");
  property p_fault_set; protection_error_in [*4] |-> fault_out; endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault output not closed");
  property p_fault_amp; fault_out && $past(fault_out) |-> !amplifier_on_out; endproperty
  a_fault_amp: assert property (p_fault_amp) else $error("amplifier on during fault");
  // Fault stays latched unless a recent disable fall could clear it
  property p_fault_hold; (!amplifier_disable_in) [*8] ##0 fault_out |=> fault_out; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared by itself");
  property p_recover;
    (!protection_error_in) [*4] ##0 $fell(amplifier_disable_in)
      |-> ##[1:7] (!fault_out && amplifier_on_out);
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery on disable fall");
  property p_res; $stable(res_code) [*6] |-> resolution_out == RES_T[res_code]; endproperty
  a_res: assert property (p_res) else $error("resolution decode wrong");
  property p_inertia; $stable(inertia_switch_in) [*6] |-> high_inertia_out == !inertia_switch_in;
  endproperty
  a_inertia: assert property (p_inertia) else $error("inertia selection wrong");
  property p_test_off; selftest_switch_in [*6] |-> !selftest_busy_out; endproperty
  a_test_off: assert property (p_test_off) else $error("self test with switch off");
  c_step: cover property (microstep_out);
  c_fault: cover property ($rose(fault_out));
  c_test: cover property ($fell(selftest_busy_out));
endmodule : sdf_front_end_monitor
`default_nettype wire

// ### tb/sdf_motion_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_motion_ctrl (
  input wire logic clk_in,
  input wire logic go_in, // Start one burst
  input wire logic cw_in, // Direction of the burst
  input wire logic [7:0] half_in, // Cycles per half period
  input wire logic [9:0] count_in, // Steps in the burst
  output logic step_out,
  output logic dir_out,
  output logic done_out
);
  // ==========================================================
  // Burst generator, step line idles high
  // ==========================================================
  initial begin
    step_out = 1'b1;
    dir_out = 1'b1;
    done_out = 1'b1;
  end
  always @(posedge clk_in) begin
    if (go_in && done_out) begin
      done_out <= 1'b0;
      dir_out <= cw_in;
      // Direction settles before the first fall
      repeat (20) @(posedge clk_in);
      for (int i = 0; i < count_in; i++) begin
        step_out <= 1'b0;
        repeat (half_in) @(posedge clk_in);
        step_out <= 1'b1;
        repeat (half_in) @(posedge clk_in);
      end
      done_out <= 1'b1;
    end
  end
endmodule : sdf_motion_ctrl
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; \
  if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t %s", $time, m); end end
module tb_top import sdf_pkg::*; ;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam logic [14:0] RES_T [16] = '{15'h00C8, 15'h0190, 15'h0320, 15'h0640, 15'h0C80,
    15'h1900, 15'h3200, 15'h6400, RES_8, RES_9, RES_10, RES_11, RES_12, RES_13, RES_14, RES_15};
  localparam logic [11:0] CUR_T [8] = '{CUR_MA_0, CUR_MA_1, CUR_MA_2, CUR_MA_3,
    CUR_MA_4, CUR_MA_5, CUR_MA_6, CUR_MA_7};
  logic clk_in = 1'b0, rst_in = 1'b1, dis = 1'b0, prot = 1'b0, go = 1'b0, cw = 1'b1;
  logic [2:0] cur_sel = 3'h7; // Switch fields, OFF reads 1
  logic [3:0] res_sel = 4'h0;
  logic idle_sel = 1'b1, test_sw = 1'b1, smooth_sw = 1'b1, inert_sw = 1'b1, filt_sw = 1'b1;
  logic [7:0] half = 8'h0C;
  logic [9:0] cnt = 10'h001;
  logic step, dir, done, microstep_out, microstep_cw_out, amplifier_on_out, fault_out;
  logic high_inertia_out, selftest_busy_out;
  logic [11:0] current_ma_out;
  logic [14:0] resolution_out;
  logic exp_q [$]; // Expected microstep directions, oldest first
  int n_mismatch = 0, num_checks = 0;
  integer seed = 33; // Seed for $random

  initial begin
    forever #25 clk_in = ~clk_in;
  end
  sdf_motion_ctrl ctrl (.clk_in, .go_in(go), .cw_in(cw), .half_in(half), .count_in(cnt),
    .step_out(step), .dir_out(dir), .done_out(done));
  sdf_front_end #(.IDLE_CNT(100), .TEST_STEP_DIV(4)) dut (.clk_in, .rst_in, .step_in(step),
    .rotation_sense_in(dir), .amplifier_disable_in(dis), .protection_error_in(prot),
    .current_select_bit0_in(cur_sel[0]), .current_select_bit1_in(cur_sel[1]),
    .current_select_bit2_in(cur_sel[2]), .idle_level_select_in(idle_sel),
    .resolution_select_bit0_in(res_sel[0]), .resolution_select_bit1_in(res_sel[1]),
    .resolution_select_bit2_in(res_sel[2]), .resolution_select_bit3_in(res_sel[3]),
    .selftest_switch_in(test_sw), .smoothing_switch_in(smooth_sw), .inertia_switch_in(inert_sw),
    .input_filter_switch_in(filt_sw), .microstep_out, .microstep_cw_out, .amplifier_on_out,
    .fault_out, .current_ma_out, .resolution_out, .high_inertia_out, .selftest_busy_out);

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // One burst of k steps; e says whether the block must follow it
  task automatic burst(input logic c, input int k, input int h, input logic e);
    cw <= c;
    half <= 8'(h);
    cnt <= 10'(k);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    if (e) for (int i = 0; i < k; i++) exp_q.push_back(c);
    @(posedge clk_in);
    for (int i = 0; i < 20000 && !done; i++) @(posedge clk_in);
    if (!done) begin
      n_mismatch++;
      complete_run();
    end
  endtask : burst
  // Wait until every expected microstep has come out
  task automatic drain();
    for (int i = 0; i < 9000 && exp_q.size() != 0; i++) @(posedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1, "microsteps missing")
    if (exp_q.size() != 0) complete_run();
  endtask : drain

  // ==========================================================
  // Watcher: every microstep takes the oldest note
  // ==========================================================
  always @(posedge clk_in) begin
    if (!rst_in && microstep_out === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected microstep")
      else `CHK(microstep_cw_out, exp_q.pop_front(), "microstep direction")
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    tick(16);
    rst_in <= 1'b0;
    tick(10);
    // Every resolution code, random inertia
    for (int k = 0; k < 16; k++) begin
      res_sel <= 4'(k);
      inert_sw <= 1'($random(seed));
      tick(8);
      `CHK(resolution_out, RES_T[k], "resolution")
      `CHK(high_inertia_out, !inert_sw, "inertia")
    end
    res_sel <= 4'h0;
    // Every current code, running then idle, both idle levels
    for (int k = 0; k < 8; k++) begin
      cur_sel <= 3'(k);
      idle_sel <= k[0];
      burst(1'($random(seed)), 1, 12, 1'b1);
      tick(12);
      `CHK(current_ma_out, CUR_T[k], "running current")
      tick(120);
      `CHK(current_ma_out, 12'((32'(CUR_T[k]) * (k[0] ? 90 : 50)) / 100), "idle current")
    end
    // Back-to-back steps with a reversal
    burst(1'b1, 5, 12, 1'b1);
    burst(1'b0, 5, 12, 1'b1);
    // Full 2 MHz rate at high bandwidth
    burst(1'b1, 4, 5, 1'b1);
    // Pulses shorter than the filter hold are dropped, then a long one at low bandwidth
    burst(1'b1, 1, 4, 1'b0);
    filt_sw <= 1'b0;
    tick(4);
    burst(1'b1, 1, 60, 1'b0);
    burst(1'b1, 1, 140, 1'b1);
    filt_sw <= 1'b1;
    drain();
    // Disabled amplifier ignores steps
    dis <= 1'b1;
    tick(6);
    `CHK(amplifier_on_out, 1'b0, "amplifier disable")
    `CHK(current_ma_out, 12'h000, "current while disabled")
    burst(1'b1, 2, 12, 1'b0);
    dis <= 1'b0;
    tick(8);
    `CHK(amplifier_on_out, 1'b1, "amplifier enable")
    // Protection error: latched, recovery refused while cause present
    prot <= 1'b1;
    tick(6);
    `CHK(fault_out, 1'b1, "fault set")
    `CHK(amplifier_on_out, 1'b0, "amplifier off on fault")
    for (int r = 0; r < 2; r++) begin
      if (r == 1) prot <= 1'b0;
      tick(10);
      `CHK(fault_out, 1'b1, "fault latched")
      dis <= 1'b1;
      tick(6);
      dis <= 1'b0;
      tick(8);
    end
    `CHK(fault_out, 1'b0, "fault cleared")
    `CHK(amplifier_on_out, 1'b1, "amplifier restored")
    // Self test: two revolutions each way at 200 steps per revolution
    test_sw <= 1'b0;
    for (int i = 0; i < 800; i++) exp_q.push_back(i < 400);
    tick(10);
    `CHK(selftest_busy_out, 1'b1, "self test start")
    for (int i = 0; i < 8000 && selftest_busy_out !== 1'b0; i++) @(posedge clk_in);
    `CHK(selftest_busy_out, 1'b0, "self test end")
    if (selftest_busy_out !== 1'b0) complete_run();
    drain();
    test_sw <= 1'b1;
    // Smoothing still delivers every step, only later
    smooth_sw <= 1'b0;
    tick(4);
    burst(1'b1, 4, 12, 1'b1);
    drain();
    smooth_sw <= 1'b1;
    complete_run();
  end
endmodule : tb_top
bind sdf_front_end sdf_front_end_monitor mon (.clk_in, .rst_in, .amplifier_disable_in,
  .protection_error_in, .resolution_select_bit0_in, .resolution_select_bit1_in,
  .resolution_select_bit2_in, .resolution_select_bit3_in, .inertia_switch_in,
  .selftest_switch_in, .microstep_out, .amplifier_on_out, .fault_out, .current_ma_out,
  .resolution_out, .high_inertia_out, .selftest_busy_out);
`default_nettype wire
